// ==== shared/frs_params.svh ====
// Constants for the fast role swap and vendor alert register bank
`ifndef FRS_PARAMS_SVH
`define FRS_PARAMS_SVH

// Register addresses
`define ADDR_SRC_SWAP      8'hB1
`define ADDR_SNK_SWAP      8'hB2
`define ADDR_ALERT         8'hB3
`define ADDR_ALERT_MASK    8'hB4

// Reset values
`define RST_SRC_SWAP       8'h00
`define RST_SNK_SWAP       8'h00
`define RST_ALERT          7'h00
`define RST_ALERT_MASK     7'h7F

// Source and sink swap register fields
`define SRC_START_BIT      0
`define SRC_MANUAL_BIT     1
`define SRC_DLY_LSB        2
`define SRC_DLY_MSB        3
`define SNK_ARM_BIT        0

// Alert bit positions
`define AL_SWAP_RX         0
`define AL_SWAP_TX         1
`define AL_OVER_TEMP       2
`define AL_SUPPLY          3
`define AL_GPI1            4
`define AL_GPI2            5
`define AL_DISCHARGE       6
`define ALERT_W            7

// Delay codes and times
`define DLY_CODE_0         2'h0
`define DLY_CODE_150       2'h1
`define DLY_CODE_300       2'h2
`define DLY_150_US         150
`define DLY_300_US         300
`define DLY_600_US         600
`define MCLK_MHZ           250

`endif

// ==== shared/frs_pkg.sv ====
// Types for the fast role swap register bank
package frs_pkg;

	// Swap sequencer states, one-hot
	typedef enum logic [2:0] {
		ST_IDLE   = 3'b001,
		ST_SIGNAL = 3'b010,
		ST_DELAY  = 3'b100
	} swap_state_e;

	typedef logic [1:0] delay_sel_t;

endpackage : frs_pkg

// ==== verilog/input_edge_watch.sv ====
// Change and falling-edge detector for a group of synchronous inputs
`timescale 1ns/1ps
`default_nettype none

module input_edge_watch #(
	parameter int unsigned WIDTH = 3
) (
	input  wire logic             mclk_i,
	input  wire logic             reset_i,
	input  wire logic [WIDTH-1:0] level_i,
	output logic      [WIDTH-1:0] change_o,
	output logic      [WIDTH-1:0] fall_o
);

	logic [WIDTH-1:0] prev_ff;
	logic [WIDTH-1:0] nxt_prev;
	logic             seen_ff;
	logic             nxt_seen;

	if (WIDTH < 1) begin : g_bad_width
		$error("input_edge_watch needs at least one input");
	end

	////////////////////////////////////////////////////////////////////////
	// Next history; first sample only primes it
	always_comb
	begin
		nxt_prev = level_i;
		nxt_seen = 1'b1;
	end

	always_ff @(posedge mclk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			prev_ff <= '0;
			seen_ff <= 1'b0;
		end
		else
		begin
			prev_ff <= nxt_prev;
			seen_ff <= nxt_seen;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Per-bit edge decode
	for (genvar i = 0; i < WIDTH; i++) begin : g_bit
		assign change_o[i] = seen_ff & (level_i[i] ^ prev_ff[i]);
		assign fall_o[i]   = seen_ff & prev_ff[i] & ~level_i[i];
	end

endmodule : input_edge_watch

`default_nettype wire

// ==== verilog/sink_delay_timer.sv ====
// Down-counter giving a one-cycle done pulse after a loaded count
`timescale 1ns/1ps
`default_nettype none

module sink_delay_timer #(
	parameter int unsigned CNT_W = 18
) (
	input  wire logic             mclk_i,
	input  wire logic             reset_i,
	input  wire logic             load_i,
	input  wire logic [CNT_W-1:0] count_i,
	output logic                  done_o
);

	logic [CNT_W-1:0] cnt_ff;
	logic [CNT_W-1:0] nxt_cnt;
	logic             done_ff;
	logic             nxt_done;

	if (CNT_W < 2) begin : g_bad_width
		$error("sink_delay_timer counter too narrow");
	end

	////////////////////////////////////////////////////////////////////////
	// Count down to one, then pulse done
	always_comb
	begin
		nxt_cnt  = cnt_ff;
		nxt_done = 1'b0;
		if (load_i)
			nxt_cnt = count_i;
		else if (cnt_ff == CNT_W'(1))
		begin
			nxt_cnt  = '0;
			nxt_done = 1'b1;
		end
		else if (cnt_ff != '0)
			nxt_cnt = cnt_ff - CNT_W'(1);
	end

	always_ff @(posedge mclk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			cnt_ff  <= '0;
			done_ff <= 1'b0;
		end
		else
		begin
			cnt_ff  <= nxt_cnt;
			done_ff <= nxt_done;
		end
	end

	assign done_o = done_ff;

endmodule : sink_delay_timer

`default_nettype wire

// ==== verilog/role_swap_regs.sv ====
// Fast role swap control and vendor alert register bank
//
// Contract
// - Auto sink gate turns on after 0, 150, 300 or 600 us by code.
// - Zero delay timed from start bit; others from end of swap signalling.
// - Manual bit 0 means automatic sink gate; 1 leaves it to software.
// - Writing 1 to source bit 0 starts swap; 0 ignored; bit self-clears.
// - Writing 1 to sink bit 0 arms detection; cleared when swap detected.
// - Alert bits clear only on write of 1; writing 0 keeps them.
// - Alert bit 6 set on successful bus discharge.
// - Alert bit 5 on input two change, bit 4 on input one change.
// - Alert bit 3 on any supply detection change.
// - Alert bit 2 on over-temperature condition.
// - Alert bit 1 when swap signal sent due to input two going low.
// - Alert bit 0 when swap request received from partner.
// - Mask bit 1 unmasks its alert; mask resets to 0x7F.
// - Pin two swap mode, output off: falling input starts a swap.
`timescale 1ns/1ps
`default_nettype none
`include "frs_params.svh"

module role_swap_regs #(
	parameter int unsigned CYC_150 = `DLY_150_US * `MCLK_MHZ,
	parameter int unsigned CYC_300 = `DLY_300_US * `MCLK_MHZ,
	parameter int unsigned CYC_600 = `DLY_600_US * `MCLK_MHZ
) (
	input  wire logic       mclk_i,
	input  wire logic       reset_i,
	input  wire logic [7:0] reg_addr_i,
	input  wire logic [7:0] reg_wdata_i,
	input  wire logic       reg_wr_i,
	input  wire logic       reg_rd_i,
	input  wire logic       discharge_done_i,
	input  wire logic       input_one_i,
	input  wire logic       input_two_i,
	input  wire logic       supply_detect_i,
	input  wire logic       over_temp_i,
	input  wire logic       swap_signal_done_i,
	input  wire logic       swap_request_rx_i,
	input  wire logic       pin_two_swap_function_i,
	input  wire logic       pin_two_output_enable_i,
	input  wire logic       sink_gate_release_i,
	output logic [7:0]      reg_rdata_o,
	output logic            reg_rvalid_o,
	output logic            swap_tx_start_o,
	output logic            sink_gate_en_o,
	output logic            int_req_n_o
);

	localparam int unsigned CNT_W = $clog2(CYC_600 + 1);

	if (CYC_150 < 1 || CYC_300 < CYC_150 || CYC_600 < CYC_300)
	begin : g_bad_delay
		$error("role_swap_regs delay counts must be ascending and nonzero");
	end

	// Address compare, shared by read and write decode
	function automatic logic addr_hit(input logic [7:0] a,
		input logic [7:0] t);
		addr_hit = (a == t);
	endfunction : addr_hit

	// Delay code to cycle count
	function automatic logic [CNT_W-1:0] delay_cycles(
		input frs_pkg::delay_sel_t s);
		case (s)
			`DLY_CODE_150: delay_cycles = CNT_W'(CYC_150);
			`DLY_CODE_300: delay_cycles = CNT_W'(CYC_300);
			default:       delay_cycles = CNT_W'(CYC_600);
		endcase
	endfunction : delay_cycles

	////////////////////////////////////////////////////////////////////////
	// Register state
	frs_pkg::swap_state_e     state_ff, nxt_state;
	frs_pkg::delay_sel_t      sink_gate_delay_sel_ff, nxt_delay_sel;
	logic                     sink_gate_by_software_ff, nxt_manual;
	logic                     role_swap_start_ff, nxt_start;
	logic                     role_swap_detect_arm_ff, nxt_arm;
	logic                     cause_pin_ff, nxt_cause_pin;
	logic [`ALERT_W-1:0]      alert_ff, nxt_alert;
	logic [`ALERT_W-1:0]      mask_ff, nxt_mask;
	logic                     sink_gate_ff, nxt_sink_gate;
	logic                     tx_start_ff, nxt_tx_start;
	logic                     int_n_ff, nxt_int_n;
	logic [7:0]               rdata_ff, nxt_rdata;
	logic                     rvalid_ff, nxt_rvalid;
	logic                     timer_load;
	logic [CNT_W-1:0]         timer_count;
	logic                     timer_done;
	logic [3:0]               in_change;
	logic [3:0]               in_fall;
	logic                     wr_src, wr_snk, wr_alert, wr_mask;
	logic                     sw_start, pin_start, start_go;
	logic [`ALERT_W-1:0]      alert_set;

	////////////////////////////////////////////////////////////////////////
	// Input edge detection: one, two, supply, over-temperature
	input_edge_watch #(
		.WIDTH (4)
	) u_edges (
		.mclk_i   (mclk_i),
		.reset_i  (reset_i),
		.level_i  ({over_temp_i, supply_detect_i, input_two_i,
			input_one_i}),
		.change_o (in_change),
		.fall_o   (in_fall)
	);

	sink_delay_timer #(
		.CNT_W (CNT_W)
	) u_timer (
		.mclk_i  (mclk_i),
		.reset_i (reset_i),
		.load_i  (timer_load),
		.count_i (timer_count),
		.done_o  (timer_done)
	);

	////////////////////////////////////////////////////////////////////////
	// Write decode and swap start sources
	assign wr_src   = reg_wr_i & addr_hit(reg_addr_i, `ADDR_SRC_SWAP);
	assign wr_snk   = reg_wr_i & addr_hit(reg_addr_i, `ADDR_SNK_SWAP);
	assign wr_alert = reg_wr_i & addr_hit(reg_addr_i, `ADDR_ALERT);
	assign wr_mask  = reg_wr_i & addr_hit(reg_addr_i, `ADDR_ALERT_MASK);
	assign sw_start = wr_src & reg_wdata_i[`SRC_START_BIT];
	assign pin_start = pin_two_swap_function_i & ~pin_two_output_enable_i
		& in_fall[1];
	assign start_go = (state_ff == frs_pkg::ST_IDLE)
		& (sw_start | pin_start);

	////////////////////////////////////////////////////////////////////////
	// Swap sequencer and control register next values
	always_comb
	begin
		nxt_state     = state_ff;
		nxt_delay_sel = sink_gate_delay_sel_ff;
		nxt_manual    = sink_gate_by_software_ff;
		nxt_start     = role_swap_start_ff;
		nxt_arm       = role_swap_detect_arm_ff;
		nxt_cause_pin = cause_pin_ff;
		nxt_sink_gate = sink_gate_ff & ~sink_gate_release_i;
		nxt_tx_start  = 1'b0;
		timer_load    = 1'b0;
		timer_count   = delay_cycles(sink_gate_delay_sel_ff);
		if (wr_src)
		begin
			nxt_delay_sel = reg_wdata_i[`SRC_DLY_MSB:`SRC_DLY_LSB];
			nxt_manual    = reg_wdata_i[`SRC_MANUAL_BIT];
		end
		case (state_ff)
			frs_pkg::ST_IDLE:
			begin
				if (start_go)
				begin
					nxt_state     = frs_pkg::ST_SIGNAL;
					nxt_start     = 1'b1;
					nxt_cause_pin = ~sw_start;
					nxt_tx_start  = 1'b1;
					if (!sink_gate_by_software_ff && sink_gate_delay_sel_ff
						== `DLY_CODE_0)
						nxt_sink_gate = 1'b1;
				end
			end
			frs_pkg::ST_SIGNAL:
			begin
				if (swap_signal_done_i)
				begin
					nxt_start = 1'b0;
					if (!sink_gate_by_software_ff && sink_gate_delay_sel_ff
						!= `DLY_CODE_0)
					begin
						nxt_state  = frs_pkg::ST_DELAY;
						timer_load = 1'b1;
					end
					else
						nxt_state = frs_pkg::ST_IDLE;
				end
			end
			frs_pkg::ST_DELAY:
			begin
				if (timer_done)
				begin
					nxt_sink_gate = 1'b1;
					nxt_state     = frs_pkg::ST_IDLE;
				end
			end
			default:
				nxt_state = frs_pkg::ST_IDLE;
		endcase
		// Detect arm: detection wins over a same-cycle write
		if (wr_snk && reg_wdata_i[`SNK_ARM_BIT])
			nxt_arm = 1'b1;
		if (role_swap_detect_arm_ff && swap_request_rx_i)
			nxt_arm = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// Alert events, write-one-to-clear with set priority
	always_comb
	begin
		alert_set = '0;
		alert_set[`AL_DISCHARGE] = discharge_done_i;
		alert_set[`AL_GPI2]      = in_change[1];
		alert_set[`AL_GPI1]      = in_change[0];
		alert_set[`AL_SUPPLY]    = in_change[2];
		alert_set[`AL_OVER_TEMP] = in_change[3] & over_temp_i;
		alert_set[`AL_SWAP_TX]   = (state_ff == frs_pkg::ST_SIGNAL)
			& swap_signal_done_i & cause_pin_ff;
		alert_set[`AL_SWAP_RX]   = role_swap_detect_arm_ff
			& swap_request_rx_i;
		nxt_alert = alert_ff;
		if (wr_alert)
			nxt_alert = alert_ff & ~reg_wdata_i[`ALERT_W-1:0];
		nxt_alert = nxt_alert | alert_set;
		nxt_mask  = wr_mask ? reg_wdata_i[`ALERT_W-1:0] : mask_ff;
		nxt_int_n = ~|(nxt_alert & nxt_mask);
	end

	////////////////////////////////////////////////////////////////////////
	// Read data, reserved bits zero
	always_comb
	begin
		nxt_rvalid = reg_rd_i;
		nxt_rdata  = 8'h00;
		if (reg_rd_i)
		begin
			if (addr_hit(reg_addr_i, `ADDR_SRC_SWAP))
				nxt_rdata = {4'h0, sink_gate_delay_sel_ff,
					sink_gate_by_software_ff, role_swap_start_ff};
			else if (addr_hit(reg_addr_i, `ADDR_SNK_SWAP))
				nxt_rdata = {7'h00, role_swap_detect_arm_ff};
			else if (addr_hit(reg_addr_i, `ADDR_ALERT))
				nxt_rdata = {1'b0, alert_ff};
			else if (addr_hit(reg_addr_i, `ADDR_ALERT_MASK))
				nxt_rdata = {1'b0, mask_ff};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// State registers
	always_ff @(posedge mclk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			state_ff                 <= frs_pkg::ST_IDLE;
			sink_gate_delay_sel_ff   <= frs_pkg::delay_sel_t'(
				`RST_SRC_SWAP >> `SRC_DLY_LSB);
			sink_gate_by_software_ff <= 1'b0;
			role_swap_start_ff       <= 1'b0;
			role_swap_detect_arm_ff  <= 1'b0;
			cause_pin_ff             <= 1'b0;
			alert_ff                 <= `RST_ALERT;
			mask_ff                  <= `RST_ALERT_MASK;
			sink_gate_ff             <= 1'b0;
			tx_start_ff              <= 1'b0;
			int_n_ff                 <= 1'b1;
			rdata_ff                 <= 8'h00;
			rvalid_ff                <= 1'b0;
		end
		else
		begin
			state_ff                 <= nxt_state;
			sink_gate_delay_sel_ff   <= nxt_delay_sel;
			sink_gate_by_software_ff <= nxt_manual;
			role_swap_start_ff       <= nxt_start;
			role_swap_detect_arm_ff  <= nxt_arm;
			cause_pin_ff             <= nxt_cause_pin;
			alert_ff                 <= nxt_alert;
			mask_ff                  <= nxt_mask;
			sink_gate_ff             <= nxt_sink_gate;
			tx_start_ff              <= nxt_tx_start;
			int_n_ff                 <= nxt_int_n;
			rdata_ff                 <= nxt_rdata;
			rvalid_ff                <= nxt_rvalid;
		end
	end

	assign reg_rdata_o     = rdata_ff;
	assign reg_rvalid_o    = rvalid_ff;
	assign swap_tx_start_o = tx_start_ff;
	assign sink_gate_en_o  = sink_gate_ff;
	assign int_req_n_o     = int_n_ff;

	////////////////////////////////////////////////////////////////////////
	// Checks
	sequence s_auto_zero_start;
		start_go && !sink_gate_by_software_ff
			&& sink_gate_delay_sel_ff == `DLY_CODE_0;
	endsequence

	sequence s_signal_end;
		state_ff == frs_pkg::ST_SIGNAL && swap_signal_done_i;
	endsequence

	property p_zero_delay;
		@(posedge mclk_i) disable iff (reset_i)
		s_auto_zero_start |=> sink_gate_en_o && swap_tx_start_o;
	endproperty
	a_zero_delay: assert property (p_zero_delay)
		else $error("zero delay sink gate not enabled with start");

	property p_start_clears;
		@(posedge mclk_i) disable iff (reset_i)
		s_signal_end |=> !role_swap_start_ff
			&& $past(role_swap_start_ff);
	endproperty
	a_start_clears: assert property (p_start_clears)
		else $error("start bit did not self clear");

	property p_manual_no_gate;
		@(posedge mclk_i) disable iff (reset_i)
		sink_gate_by_software_ff && !wr_src && !sink_gate_en_o
			|=> !sink_gate_en_o;
	endproperty
	a_manual_no_gate: assert property (p_manual_no_gate)
		else $error("sink gate enabled in manual mode");

	property p_delay_gate;
		@(posedge mclk_i) disable iff (reset_i)
		state_ff == frs_pkg::ST_DELAY && timer_done
			|=> sink_gate_en_o && state_ff == frs_pkg::ST_IDLE;
	endproperty
	a_delay_gate: assert property (p_delay_gate)
		else $error("sink gate not enabled after delay");

	property p_arm_clear;
		@(posedge mclk_i) disable iff (reset_i)
		role_swap_detect_arm_ff && swap_request_rx_i
			|=> !role_swap_detect_arm_ff && alert_ff[`AL_SWAP_RX];
	endproperty
	a_arm_clear: assert property (p_arm_clear)
		else $error("detect arm not cleared or alert not set");

	property p_w1c;
		@(posedge mclk_i) disable iff (reset_i)
		wr_alert && alert_set == '0
			|=> alert_ff == ($past(alert_ff)
				& ~$past(reg_wdata_i[`ALERT_W-1:0]));
	endproperty
	a_w1c: assert property (p_w1c)
		else $error("alert write one to clear misbehaved");

	property p_discharge;
		@(posedge mclk_i) disable iff (reset_i)
		discharge_done_i |=> alert_ff[`AL_DISCHARGE];
	endproperty
	a_discharge: assert property (p_discharge)
		else $error("discharge alert not set");

	property p_input_one;
		@(posedge mclk_i) disable iff (reset_i)
		in_change[0] |=> alert_ff[`AL_GPI1];
	endproperty
	a_input_one: assert property (p_input_one)
		else $error("input one change alert not set");

	property p_irq;
		@(posedge mclk_i) disable iff (reset_i)
		##1 (int_req_n_o == !(|(alert_ff & mask_ff)));
	endproperty
	a_irq: assert property (p_irq)
		else $error("interrupt request disagrees with alerts");

	property p_pin_start;
		@(posedge mclk_i) disable iff (reset_i)
		pin_start && state_ff == frs_pkg::ST_IDLE && !sw_start
			|=> swap_tx_start_o ##0 cause_pin_ff;
	endproperty
	a_pin_start: assert property (p_pin_start)
		else $error("pin two fall did not start swap");

endmodule : role_swap_regs

`default_nettype wire

// ==== tb/swap_line_model.sv ====
// Line-side model: answers a swap start with a signalling-done pulse
`timescale 1ns/1ps
`default_nettype none

module swap_line_model (
	input  wire logic       mclk_i,
	input  wire logic       reset_i,
	input  wire logic [7:0] delay_i,
	input  wire logic       swap_tx_start_i,
	output logic            swap_signal_done_o
);
	logic [8:0] cnt_ff;

	// Count down from each start pulse, then flag done for one cycle
	always_ff @(posedge mclk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			cnt_ff             <= 9'h000;
			swap_signal_done_o <= 1'b0;
		end
		else
		begin
			swap_signal_done_o <= (cnt_ff == 9'h001);
			if (swap_tx_start_i)
				cnt_ff <= {1'b0, delay_i} + 9'h001;
			else if (cnt_ff != 9'h000)
				cnt_ff <= cnt_ff - 9'h001;
		end
	end
endmodule : swap_line_model

`default_nettype wire

// ==== tb/test_fast_role_swap_alert_regs.sv ====
// Self-checking bench for the role swap and vendor alert registers
`timescale 1ns/1ps
`default_nettype none
`include "frs_params.svh"

module test_fast_role_swap_alert_regs;
	localparam int C150 = 10;
	localparam int C300 = 20;
	localparam int C600 = 40;
	localparam int LIMIT = 5000;

	logic       mclk_i = 1'b0;
	logic       reset_i = 1'b1;
	logic [7:0] reg_addr_i = 8'h00;
	logic [7:0] reg_wdata_i = 8'h00;
	logic       reg_wr_i = 1'b0;
	logic       reg_rd_i = 1'b0;
	logic       discharge_done_i = 1'b0;
	logic       input_one_i = 1'b0;
	logic       input_two_i = 1'b0;
	logic       supply_detect_i = 1'b0;
	logic       over_temp_i = 1'b0;
	logic       swap_request_rx_i = 1'b0;
	logic       pin_fn = 1'b0;
	logic       pin_oe = 1'b0;
	logic       gate_rel = 1'b0;
	logic [7:0] line_dly = 8'h06;
	logic       swap_signal_done_i;
	logic [7:0] reg_rdata_o;
	logic       reg_rvalid_o;
	logic       swap_tx_start_o;
	logic       sink_gate_en_o;
	logic       int_req_n_o;
	logic       gate_q = 1'b0;
	logic [7:0] expq[$];
	logic [31:0] seed = 32'hEE05B028;
	int n_errors = 0;
	int num_checks = 0;
	int cyc = 0;
	int n_tx = 0;
	int tx_cyc = 0;
	int done_cyc = 0;
	int gate_cyc = -1;
	int n0;
	int g;
	int exp_g[5] = '{0, C150 + 2, C300 + 2, C600 + 2, -1};

	role_swap_regs #(.CYC_150(C150), .CYC_300(C300), .CYC_600(C600)) dut (
		.mclk_i(mclk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
		.discharge_done_i(discharge_done_i), .input_one_i(input_one_i),
		.input_two_i(input_two_i), .supply_detect_i(supply_detect_i),
		.over_temp_i(over_temp_i), .swap_signal_done_i(swap_signal_done_i),
		.swap_request_rx_i(swap_request_rx_i),
		.pin_two_swap_function_i(pin_fn), .pin_two_output_enable_i(pin_oe),
		.sink_gate_release_i(gate_rel), .reg_rdata_o(reg_rdata_o),
		.reg_rvalid_o(reg_rvalid_o), .swap_tx_start_o(swap_tx_start_o),
		.sink_gate_en_o(sink_gate_en_o), .int_req_n_o(int_req_n_o));

	swap_line_model line (
		.mclk_i(mclk_i), .reset_i(reset_i), .delay_i(line_dly),
		.swap_tx_start_i(swap_tx_start_o),
		.swap_signal_done_o(swap_signal_done_i));

	// Clock at 250 MHz
	always #2 mclk_i = ~mclk_i;

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction : xs

	task automatic conclude();
		if (n_errors == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : conclude

	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("ERROR %s expected %0h seen %0h", what, exp, seen);
		end
	endtask : check

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk_i);
		reg_addr_i  <= a;
		reg_wdata_i <= d;
		reg_wr_i    <= 1'b1;
		@(posedge mclk_i);
		reg_wr_i <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge mclk_i);
		reg_addr_i <= a;
		reg_rd_i   <= 1'b1;
		expq.push_back(e);
		@(posedge mclk_i);
		reg_rd_i <= 1'b0;
		@(posedge mclk_i);
	endtask : rd

	// Raise one alert source: pulse, level toggle or rising edge
	task automatic fire(input int k);
		@(posedge mclk_i);
		case (k)
			6: discharge_done_i <= 1'b1;
			5: input_two_i <= ~input_two_i;
			4: input_one_i <= ~input_one_i;
			3: supply_detect_i <= ~supply_detect_i;
			2: over_temp_i <= 1'b1;
			default: swap_request_rx_i <= 1'b1;
		endcase
		@(posedge mclk_i);
		discharge_done_i  <= 1'b0;
		swap_request_rx_i <= 1'b0;
		over_temp_i       <= 1'b0;
		repeat (2) @(posedge mclk_i);
	endtask : fire

	// Watcher: read scoreboard, swap timing marks and the run ceiling
	always @(posedge mclk_i)
	begin
		cyc++;
		if (cyc == LIMIT)
		begin
			n_errors++;
			conclude();
		end
		if (reg_rvalid_o === 1'b1)
		begin
			check("read pending", expq.size() != 0, 1);
			if (expq.size() != 0)
				check("reg_rdata_o", reg_rdata_o, expq.pop_front());
		end
		if (swap_tx_start_o === 1'b1)
		begin
			n_tx++;
			tx_cyc = cyc;
		end
		if (swap_signal_done_i === 1'b1)
			done_cyc = cyc;
		if (sink_gate_en_o === 1'b1 && gate_q !== 1'b1)
			gate_cyc = cyc;
		gate_q = sink_gate_en_o;
	end

	// Main sequence
	initial
	begin
		repeat (10) @(posedge mclk_i);
		reset_i <= 1'b0;
		rd(`ADDR_SRC_SWAP, 8'h00);
		rd(`ADDR_SNK_SWAP, 8'h00);
		rd(`ADDR_ALERT, 8'h00);
		rd(`ADDR_ALERT_MASK, 8'h7F);
		rd(8'hB5, 8'h00);
		check("int_req_n_o", int_req_n_o, 1);
		wr(`ADDR_SNK_SWAP, 8'hFE);
		rd(`ADDR_SNK_SWAP, 8'h00);
		for (int i = 0; i < 4; i++)
		begin
			seed = xs(seed);
			wr(`ADDR_ALERT_MASK, seed[7:0]);
			rd(`ADDR_ALERT_MASK, seed[7:0] & 8'h7F);
		end
		wr(`ADDR_ALERT_MASK, 8'h7F);
		// Each alert source except bit 1: set, write-0 keeps, write-1 clears
		for (int k = 0; k < 7; k++)
		begin
			if (k == 1)
				continue;
			if (k == 0)
			begin
				wr(`ADDR_SNK_SWAP, 8'h01);
				rd(`ADDR_SNK_SWAP, 8'h01);
			end
			fire(k);
			check("int_req_n_o", int_req_n_o, 0);
			rd(`ADDR_SNK_SWAP, 8'h00);
			rd(`ADDR_ALERT, 8'h01 << k);
			wr(`ADDR_ALERT, ~(8'h01 << k));
			rd(`ADDR_ALERT, 8'h01 << k);
			wr(`ADDR_ALERT, 8'h01 << k);
			rd(`ADDR_ALERT, 8'h00);
			check("int_req_n_o", int_req_n_o, 1);
		end
		// Masked alert keeps the request released
		wr(`ADDR_ALERT_MASK, 8'h00);
		fire(6);
		check("int_req_n_o", int_req_n_o, 1);
		rd(`ADDR_ALERT, 8'h40);
		wr(`ADDR_ALERT, 8'h40);
		wr(`ADDR_ALERT_MASK, 8'h7F);
		// Software swap for each delay code, then manual mode
		for (int c = 0; c < 5; c++)
		begin
			line_dly <= 8'(6 + 3 * c);
			n0 = n_tx;
			gate_cyc = -1;
			wr(`ADDR_SRC_SWAP, (c == 4) ? 8'h0E : 8'(c << 2));
			wr(`ADDR_SRC_SWAP, (c == 4) ? 8'h0F : 8'((c << 2) | 1));
			rd(`ADDR_SRC_SWAP, (c == 4) ? 8'h0F : 8'((c << 2) | 1));
			repeat (70) @(posedge mclk_i);
			check("swap starts", n_tx - n0, 1);
			g = (gate_cyc < 0) ? -1 : gate_cyc - ((c == 0) ? tx_cyc : done_cyc);
			check("sink gate delay", g, exp_g[c]);
			rd(`ADDR_SRC_SWAP, (c == 4) ? 8'h0E : 8'(c << 2));
			@(posedge mclk_i);
			gate_rel <= 1'b1;
			@(posedge mclk_i);
			gate_rel <= 1'b0;
		end
		rd(`ADDR_ALERT, 8'h00);
		// Pin-triggered swap: ignored with driver on, taken with it off
		n0 = n_tx;
		@(posedge mclk_i);
		pin_fn <= 1'b1;
		pin_oe <= 1'b1;
		@(posedge mclk_i);
		input_two_i <= 1'b0;
		repeat (3) @(posedge mclk_i);
		pin_oe      <= 1'b0;
		input_two_i <= 1'b1;
		@(posedge mclk_i);
		input_two_i <= 1'b0;
		repeat (40) @(posedge mclk_i);
		check("pin swap starts", n_tx - n0, 1);
		rd(`ADDR_ALERT, 8'h22);
		@(posedge mclk_i);
		check("reads unanswered", expq.size(), 0);
		conclude();
	end
endmodule : test_fast_role_swap_alert_regs

`default_nettype wire
